//--- cri_top.v
// The implementer's own choice: register access over AHB-Lite.
`timescale 1ns/1ps
`include "cri_regs.vh"
module cri_top (
  input wire clk, // bus clock, 25 MHz
  input wire reset, // synchronous, active high
  input wire hsel, // ahb slave select
  input wire [31:0] haddr, // ahb address
  input wire [1:0] htrans, // ahb transfer type
  input wire hwrite, // ahb write
  input wire [2:0] hsize, // ahb size, word only
  input wire [31:0] hwdata, // ahb write data
  input wire hready, // ahb bus ready
  output reg hreadyout, // slave ready
  output reg hresp, // slave response, always okay
  output reg [31:0] hrdata, // read data
  input wire init_request, // initialization request
  input wire init_acknowledge, // initialization acknowledge
  input wire wakeup_flag, // wake-up event flag
  input wire overrun_flag, // data overrun flag
  input wire rx_full_flag, // receive buffer full flag
  input wire [7:0] rx_err_count, // receive error counter
  input wire [8:0] tx_err_count, // transmit error counter
  output reg wakeup_irq, // wake-up interrupt request
  output reg error_irq, // error interrupt request
  output reg rx_irq, // receiver interrupt request
  output reg status_change_flag, // status-change flag
  output reg [1:0] rx_error_state, // reported receiver state
  output reg [1:0] tx_error_state // reported transmitter state
);

  // ------------------------------------------------------------
  // helper functions
  // ------------------------------------------------------------
  function reg_hit;
    input [31:0] addr;
    input [29:0] idx;
    begin
      reg_hit = (addr[31:2] == idx);
    end
  endfunction

  // decides whether a state move counts at the given sensitivity
  function sens_hit;
    input [1:0] sens;
    input [1:0] old_st;
    input [1:0] new_st;
    reg moved;
    reg busoff_edge;
    reg err_edge;
    begin
      moved = (old_st != new_st);
      busoff_edge = (old_st == `CRI_ST_BUSOFF) != (new_st == `CRI_ST_BUSOFF);
      // a step from the error state into bus-off leaves the error state, so it counts too
      err_edge = moved & (old_st[1] | new_st[1]);
      case (sens)
        `CRI_SENS_NONE: begin
          sens_hit = 1'b0;
        end
        `CRI_SENS_BUSOFF: begin
          sens_hit = busoff_edge;
        end
        `CRI_SENS_ERR: begin
          sens_hit = err_edge;
        end
        `CRI_SENS_ALL: begin
          sens_hit = moved;
        end
        default: begin
          sens_hit = 1'b0;
        end
      endcase
    end
  endfunction

  // ------------------------------------------------------------
  // state tracking from the error counters
  // ------------------------------------------------------------
  wire [1:0] rx_cur;
  wire [1:0] tx_cur;

  cri_err_state u_err_state (
    .clk(clk),
    .reset(reset),
    .rx_err_count(rx_err_count),
    .tx_err_count(tx_err_count),
    .rx_state_r(rx_cur),
    .tx_state_r(tx_cur)
  );

  // ------------------------------------------------------------
  // ahb-lite address phase capture
  // ------------------------------------------------------------
  wire addr_ok;
  reg dp_wr_r;
  reg dp_en_hit_r;
  reg dp_flg_hit_r;

  assign addr_ok = hsel & htrans[1] & hready;

  always @(posedge clk) begin
    if (reset) begin
      dp_wr_r <= 1'b0;
      dp_en_hit_r <= 1'b0;
      dp_flg_hit_r <= 1'b0;
    end else begin
      dp_wr_r <= addr_ok & hwrite;
      dp_en_hit_r <= reg_hit(haddr, `CRI_IDX_ENABLES);
      dp_flg_hit_r <= reg_hit(haddr, `CRI_IDX_FLAGS);
    end
  end

  // ------------------------------------------------------------
  // initialization mode qualifiers
  // ------------------------------------------------------------
  wire init_active;
  wire init_quiet;

  assign init_active = init_request & init_acknowledge;
  // a write during the request/acknowledge handover is dropped too
  assign init_quiet = ~init_request & ~init_acknowledge;

  // ------------------------------------------------------------
  // receive_interrupt_enables
  // ------------------------------------------------------------
  reg [7:0] en_r;
  reg [7:0] en_nxt;
  wire en_wr;

  assign en_wr = dp_wr_r & dp_en_hit_r & init_quiet;

  always @* begin
    en_nxt = en_r;
    if (en_wr) begin
      en_nxt = hwdata[7:0];
    end
    if (init_active) begin
      en_nxt[`CRI_WAKE_EN_BIT] = 1'b0;
      en_nxt[`CRI_SC_EN_BIT] = 1'b0;
      en_nxt[`CRI_OVR_EN_BIT] = 1'b0;
      en_nxt[`CRI_RXF_EN_BIT] = 1'b0;
      // sensitivity bits are left as they are
      en_nxt[`CRI_RSENS_HI:`CRI_TSENS_LO] = en_r[`CRI_RSENS_HI:`CRI_TSENS_LO];
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      en_r <= `CRI_ENABLES_RESET;
    end else begin
      en_r <= en_nxt;
    end
  end

  // ------------------------------------------------------------
  // status-change flag and reported states
  // ------------------------------------------------------------
  reg scf_r;
  reg scf_nxt;
  reg [1:0] rx_rep_r;
  reg [1:0] tx_rep_r;
  reg [1:0] rx_rep_nxt;
  reg [1:0] tx_rep_nxt;
  wire rx_evt;
  wire tx_evt;
  wire sc_event;
  wire scf_clr;

  assign rx_evt = sens_hit(en_r[`CRI_RSENS_HI:`CRI_RSENS_LO], rx_rep_r, rx_cur);
  assign tx_evt = sens_hit(en_r[`CRI_TSENS_HI:`CRI_TSENS_LO], tx_rep_r, tx_cur);
  // comparing against the reported code catches moves made while frozen
  assign sc_event = ~scf_r & (rx_evt | tx_evt);
  assign scf_clr = dp_wr_r & dp_flg_hit_r & init_quiet & hwdata[`CRI_SCF_BIT];

  always @* begin
    scf_nxt = scf_r;
    if (init_active) begin
      scf_nxt = 1'b0;
    end else if (sc_event) begin
      scf_nxt = 1'b1;
    end else if (scf_clr) begin
      scf_nxt = 1'b0;
    end
  end

  always @* begin
    rx_rep_nxt = rx_rep_r;
    tx_rep_nxt = tx_rep_r;
    if (~scf_r) begin
      rx_rep_nxt = rx_cur;
      tx_rep_nxt = tx_cur;
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      scf_r <= 1'b0;
      rx_rep_r <= `CRI_ST_OK;
      tx_rep_r <= `CRI_ST_OK;
    end else begin
      scf_r <= scf_nxt;
      rx_rep_r <= rx_rep_nxt;
      tx_rep_r <= tx_rep_nxt;
    end
  end

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  reg [31:0] rd_word;

  // next values are used so a read right behind a write sees it
  always @* begin
    rd_word = 32'h0000_0000;
    if (reg_hit(haddr, `CRI_IDX_ENABLES)) begin
      rd_word[7:0] = en_nxt;
    end else if (reg_hit(haddr, `CRI_IDX_FLAGS)) begin
      rd_word[`CRI_WUPF_BIT] = wakeup_flag;
      rd_word[`CRI_SCF_BIT] = scf_nxt;
      rd_word[5:4] = rx_rep_nxt;
      rd_word[3:2] = tx_rep_nxt;
      rd_word[`CRI_OVRF_BIT] = overrun_flag;
      rd_word[`CRI_RXF_BIT] = rx_full_flag;
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hrdata <= (addr_ok & ~hwrite) ? rd_word : 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // interrupt requests
  // ------------------------------------------------------------
  wire wake_pend;
  wire sc_pend;
  wire ovr_pend;
  wire rxf_pend;
  reg wakeup_irq_nxt;
  reg error_irq_nxt;
  reg rx_irq_nxt;

  // each source is masked by its own enable before the lines are merged
  assign wake_pend = wakeup_flag & en_r[`CRI_WAKE_EN_BIT];
  assign sc_pend = scf_r & en_r[`CRI_SC_EN_BIT];
  assign ovr_pend = overrun_flag & en_r[`CRI_OVR_EN_BIT];
  assign rxf_pend = rx_full_flag & en_r[`CRI_RXF_EN_BIT];

  always @* begin
    wakeup_irq_nxt = wake_pend;
    error_irq_nxt = sc_pend | ovr_pend;
    rx_irq_nxt = rxf_pend;
  end

  // one flop of latency buys clean glitch-free request lines
  always @(posedge clk) begin
    if (reset) begin
      wakeup_irq <= 1'b0;
      error_irq <= 1'b0;
      rx_irq <= 1'b0;
    end else begin
      wakeup_irq <= wakeup_irq_nxt;
      error_irq <= error_irq_nxt;
      rx_irq <= rx_irq_nxt;
    end
  end

  // ------------------------------------------------------------
  // status outputs
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (reset) begin
      status_change_flag <= 1'b0;
      rx_error_state <= `CRI_ST_OK;
      tx_error_state <= `CRI_ST_OK;
    end else begin
      status_change_flag <= scf_nxt;
      rx_error_state <= rx_rep_nxt;
      tx_error_state <= tx_rep_nxt;
    end
  end

endmodule

//--- cri_regs.vh
`ifndef CRI_REGS_VH
`define CRI_REGS_VH

// ------------------------------------------------------------
// register map (word indices; byte address is four times)
// ------------------------------------------------------------
`define CRI_IDX_FLAGS 30'h0000_0004
`define CRI_IDX_ENABLES 30'h0000_0005
`define CRI_ENABLES_RESET 8'h00

// ------------------------------------------------------------
// field positions of receive_interrupt_enables
// ------------------------------------------------------------
`define CRI_WAKE_EN_BIT 7
`define CRI_SC_EN_BIT 6
`define CRI_RSENS_HI 5
`define CRI_RSENS_LO 4
`define CRI_TSENS_HI 3
`define CRI_TSENS_LO 2
`define CRI_OVR_EN_BIT 1
`define CRI_RXF_EN_BIT 0

// ------------------------------------------------------------
// field positions of receive_flag_register
// ------------------------------------------------------------
`define CRI_WUPF_BIT 7
`define CRI_SCF_BIT 6
`define CRI_OVRF_BIT 1
`define CRI_RXF_BIT 0

// ------------------------------------------------------------
// error state codes and counter limits
// ------------------------------------------------------------
`define CRI_ST_OK 2'h0
`define CRI_ST_WARN 2'h1
`define CRI_ST_ERR 2'h2
`define CRI_ST_BUSOFF 2'h3
`define CRI_SENS_NONE 2'h0
`define CRI_SENS_BUSOFF 2'h1
`define CRI_SENS_ERR 2'h2
`define CRI_SENS_ALL 2'h3
`define CRI_WARN_LIMIT 9'h060
`define CRI_ERR_LIMIT 9'h07f
`define CRI_BUSOFF_LIMIT 9'h0ff

`endif

//--- cri_err_state.v
`timescale 1ns/1ps
`include "cri_regs.vh"
module cri_err_state (
  input wire clk, // bus clock
  input wire reset, // synchronous, active high
  input wire [7:0] rx_err_count, // receive error counter
  input wire [8:0] tx_err_count, // transmit error counter
  output reg [1:0] rx_state_r, // current receiver state code
  output reg [1:0] tx_state_r // current transmitter state code
);

  // ------------------------------------------------------------
  // counter to state mapping
  // ------------------------------------------------------------
  wire tx_busoff;
  wire [1:0] tx_code;
  reg [1:0] rx_code;

  assign tx_busoff = tx_err_count > `CRI_BUSOFF_LIMIT;
  assign tx_code = tx_busoff ? `CRI_ST_BUSOFF :
                   (tx_err_count > `CRI_ERR_LIMIT) ? `CRI_ST_ERR :
                   (tx_err_count >= `CRI_WARN_LIMIT) ? `CRI_ST_WARN : `CRI_ST_OK;

  always @* begin
    if (tx_busoff) begin
      rx_code = `CRI_ST_BUSOFF;
    end else if (tx_state_r == `CRI_ST_BUSOFF) begin
      // leaving bus-off drags the receiver straight back to ok
      rx_code = `CRI_ST_OK;
    end else if ({1'b0, rx_err_count} > `CRI_ERR_LIMIT) begin
      rx_code = `CRI_ST_ERR;
    end else if ({1'b0, rx_err_count} > `CRI_WARN_LIMIT) begin
      rx_code = `CRI_ST_WARN;
    end else begin
      rx_code = `CRI_ST_OK;
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      rx_state_r <= `CRI_ST_OK;
      tx_state_r <= `CRI_ST_OK;
    end else begin
      rx_state_r <= rx_code;
      tx_state_r <= tx_code;
    end
  end

endmodule

//--- cri_chk_assertions.sv
`timescale 1ns/1ps
`include "cri_regs.vh"
module cri_chk (
  input wire clk, // bus clock
  input wire reset, // synchronous, active high
  input wire init_request, // init request
  input wire init_acknowledge, // init acknowledge
  input wire wakeup_flag, // wake-up source
  input wire overrun_flag, // overrun source
  input wire rx_full_flag, // receive full source
  input wire [7:0] rx_err_count, // receive counter
  input wire [8:0] tx_err_count, // transmit counter
  input wire wakeup_irq, // wake-up request
  input wire error_irq, // error request
  input wire rx_irq, // receiver request
  input wire status_change_flag, // status flag
  input wire [1:0] rx_error_state, // receiver state
  input wire [1:0] tx_error_state, // transmitter state
  input wire hreadyout, // slave ready
  input wire hresp, // slave response
  input wire [31:0] hrdata // read data
);
  // ------------------------------------------------------------
  // port relations
  // ------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  wake_irq_a: assert property (wakeup_irq |-> $past(wakeup_flag))
    else $error("wake-up request without its flag");
  rx_irq_a: assert property (rx_irq |-> $past(rx_full_flag))
    else $error("receive request without its flag");
  err_irq_a: assert property (error_irq |-> $past(status_change_flag || overrun_flag))
    else $error("error request without a source");
  init_hold_a: assert property ((init_request && init_acknowledge) [*2] |=> !(wakeup_irq || error_irq || rx_irq))
    else $error("request while enables are held");
  state_freeze_a: assert property ($past(status_change_flag) |-> $stable(rx_error_state) && $stable(tx_error_state))
    else $error("state moved while flag pending");
  // states lag the counters by two edges; a bus-off exit forces one cycle of ok
  rx_warn_a: assert property (!$past(reset) && !$past(reset, 2) && !$past(status_change_flag)
    && $past(rx_err_count, 2) > 8'h60 && $past(rx_err_count, 2) <= 8'h7f
    && $past(tx_err_count, 2) <= 9'h0ff && $past(tx_err_count, 3) <= 9'h0ff |-> rx_error_state == `CRI_ST_WARN)
    else $error("receiver warning code wrong");
  busoff_a: assert property (!$past(reset) && !$past(reset, 2) && !$past(status_change_flag)
    && $past(tx_err_count, 2) > 9'h0ff |-> tx_error_state == `CRI_ST_BUSOFF && rx_error_state == `CRI_ST_BUSOFF)
    else $error("bus-off code wrong");
  rx_exit_a: assert property (!$past(reset) && !$past(reset, 2) && !$past(reset, 3)
    && !$past(status_change_flag)
    && $past(tx_err_count, 3) > 9'h0ff && $past(tx_err_count, 2) <= 9'h0ff |-> rx_error_state == `CRI_ST_OK)
    else $error("receiver not ok after bus-off exit");
  bus_okay_a: assert property (hreadyout && !hresp && hrdata[31:8] == 24'h0)
    else $error("bus answer not ready okay");
endmodule

//--- testbench.sv
`timescale 1ns/1ps
`include "cri_regs.vh"
module testbench;
  localparam logic [31:0] EN_A = {`CRI_IDX_ENABLES, 2'b00};
  localparam logic [31:0] FL_A = {`CRI_IDX_FLAGS, 2'b00};
  logic clk = 0, reset = 1, hsel = 0, hwrite = 0, init_request = 0, init_acknowledge = 0;
  logic wakeup_flag = 0, overrun_flag = 0, rx_full_flag = 0, rd_ph = 0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, seed = 32'h31, v;
  logic [7:0] rx_err_count = 8'h0;
  logic [8:0] tx_err_count = 9'h0;
  wire hreadyout, hresp, wakeup_irq, error_irq, rx_irq, status_change_flag;
  wire [31:0] hrdata;
  wire [1:0] rx_error_state, tx_error_state;
  logic [31:0] exp_q[$];
  int error_cnt = 0, check_count = 0;
  always #20 clk = ~clk;
  // only whole-word transfers are issued
  cri_top i_dut (.clk, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hreadyout, .hresp, .hrdata, .init_request, .init_acknowledge, .wakeup_flag, .overrun_flag, .rx_full_flag,
    .rx_err_count, .tx_err_count, .wakeup_irq, .error_irq, .rx_irq, .status_change_flag, .rx_error_state,
    .tx_error_state);
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task check(input logic [31:0] seen, input logic [31:0] expv);
    check_count++;
    if (seen !== expv) begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, expv);
    end
  endtask
  task conclude;
    $display("checks=%0d errors=%0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  function logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // for a read, d is the expected word, noted for the monitor
  task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= w ? d : 32'h0;
    if (!w) begin
      exp_q.push_back(d);
      rd_ph <= 1'b1;
    end
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd_ph <= 1'b0;
  endtask
  always @(posedge clk) begin
    if (rd_ph && hreadyout === 1'b1) check(hrdata, exp_q.pop_front());
  end
  // the old state is settled with all sensitivity off, so only the new step can raise the flag
  task sens_case(input logic [7:0] en, input logic [7:0] r0, r1, input logic [8:0] t0, t1, input logic e);
    ahb(1, EN_A, 32'h0);
    rx_err_count <= r0;
    tx_err_count <= t0;
    wt(4);
    ahb(1, FL_A, 32'h40);
    wt(4);
    ahb(1, EN_A, {24'h0, en});
    rx_err_count <= r1;
    tx_err_count <= t1;
    wt(4);
    check(status_change_flag, e);
    check(error_irq, e);
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    wt(4);
    reset <= 1'b0;
    ahb(0, EN_A, 32'h0);
    ahb(0, 32'h40, 32'h0);
    repeat (8) begin
      seed = xs(seed);
      v = {24'h0, seed[7:0]};
      ahb(1, EN_A, v);
      ahb(0, EN_A, v);
      wakeup_flag <= seed[8];
      overrun_flag <= seed[9];
      rx_full_flag <= seed[10];
      wt(3);
      check(wakeup_irq, v[7] & seed[8]);
      check(error_irq, v[1] & seed[9]);
      check(rx_irq, v[0] & seed[10]);
    end
    init_request <= 1'b1;
    init_acknowledge <= 1'b1;
    wt(3);
    check(wakeup_irq | error_irq | rx_irq, 0);
    ahb(0, EN_A, v & 32'h3c);
    ahb(1, EN_A, 32'hff);
    ahb(0, EN_A, v & 32'h3c);
    init_request <= 1'b0;
    init_acknowledge <= 1'b0;
    ahb(1, EN_A, 32'hff);
    ahb(0, EN_A, 32'hff);
    wakeup_flag <= 1'b0;
    overrun_flag <= 1'b0;
    for (int s = 0; s < 4; s++) begin
      sens_case({2'h1, s[1:0], 4'h0}, 8'd0, 8'd100, 9'd0, 9'd0, s == 3);
      sens_case({2'h1, s[1:0], 4'h0}, 8'd100, 8'd130, 9'd0, 9'd0, s >= 2);
      sens_case({2'h1, s[1:0], 4'h0}, 8'd100, 8'd100, 9'd0, 9'd300, s >= 1);
      sens_case({4'h4, s[1:0], 2'h0}, 8'd100, 8'd100, 9'd0, 9'd100, s == 3);
      sens_case({4'h4, s[1:0], 2'h0}, 8'd0, 8'd0, 9'd100, 9'd200, s >= 2);
      sens_case({4'h4, s[1:0], 2'h0}, 8'd0, 8'd0, 9'd200, 9'd300, s >= 1);
    end
    conclude;
  end
  initial begin
    #(40 * 20000);
    error_cnt++;
    conclude;
  end
endmodule
bind cri_top cri_chk u_chk (.clk, .reset, .init_request, .init_acknowledge, .wakeup_flag, .overrun_flag,
  .rx_full_flag, .rx_err_count, .tx_err_count, .wakeup_irq, .error_irq, .rx_irq, .status_change_flag,
  .rx_error_state, .tx_error_state, .hreadyout, .hresp, .hrdata);
